// [logic/hbpf_ctrl.sv]
// Half-bridge switch command, current limit and fault reporting logic
// Function
// - Start only after enable and supplies rise
// - Mid level 50ns: high off, diode emulation
// - Stay in emulation until zero current
// - Emulation: low on while current positive
// - Current sense output off while disabled
// - Over-current turns high side off for cycle
// - Eight consecutive over-currents latch fault
// - After latch, low on until zero current, except node short
// - Negative limit: low off, high on 200ns
// - Negative limit raises no fault
// - Any fault drives fault pin high
// - Fault impedance set 200ns after report
// - Impedance encodes fault type
// - Over-temperature latches high off, drains low
// - Node short latches, pulls modulation high
`timescale 1ns/100ps
`include "hbpf_defines.svh"

module hbpf_ctrl #(
    parameter int TRI_HOLD_CYC = `HBPF_TRI_HOLD_CYC,
    parameter int NEG_ON_CYC   = `HBPF_NEG_ON_CYC,
    parameter int REPORT_CYC   = `HBPF_REPORT_CYC,
    parameter int OC_LIMIT     = `HBPF_OC_LIMIT
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  enable,
    input  wire logic                  logic_supply_ok,
    input  wire logic                  driver_supply_ok,
    input  wire hbpf_pkg::hbpf_mod_type mod_in,
    input  wire hbpf_pkg::hbpf_sense_type sense_in,
    output logic                       high_side_switch,
    output logic                       low_side_switch,
    output logic                       current_sense_out_en,
    output logic                       temp_fault_pin,
    output hbpf_pkg::hbpf_imp_type     mod_imp_sel
);
    import hbpf_pkg::*;

    // ================================================================
    // Reset release and input synchronisers
    logic            rst_s1_reg;
    logic            rst_s2_reg;
    logic            rst_int_b;
    logic [`HBPF_SYNC_W-1:0] sync1_reg;
    logic [`HBPF_SYNC_W-1:0] sync2_reg;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_reg <= 1'h0;
            rst_s2_reg <= 1'h0;
        end
        else
        begin
            rst_s1_reg <= 1'h1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_int_b = rst_s2_reg;

    // Comparator outputs are asynchronous to clk, so all pass two stages
    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {enable, logic_supply_ok, driver_supply_ok, mod_in, sense_in};
            sync2_reg <= sync1_reg;
        end
    end

    logic           en_s;
    logic           lsup_s;
    logic           dsup_s;
    logic           sup_s;
    hbpf_mod_type   mod_s;
    hbpf_sense_type sns_s;
    // Unpacked in the same order as packed into the first stage
    assign {en_s, lsup_s, dsup_s, mod_s, sns_s} = sync2_reg;
    assign sup_s = lsup_s & dsup_s;

    // ================================================================
    // Run qualification
    logic run_reg;
    logic en_d_reg;
    logic sup_d_reg;
    logic rise_seen_reg;

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            en_d_reg      <= 1'h0;
            sup_d_reg     <= 1'h0;
            rise_seen_reg <= 1'h0;
        end
        else
        begin
            en_d_reg  <= en_s;
            sup_d_reg <= sup_s;
            // Running only after a fresh rise; any drop clears faults
            if (!en_s || !sup_s)
                rise_seen_reg <= 1'h0;
            else if (!en_d_reg || !sup_d_reg)
                rise_seen_reg <= 1'h1;
        end
    end
    assign run_reg = rise_seen_reg;

    // ================================================================
    // Modulation cycle edges and over-current counting
    logic                  high_d_reg;
    logic                  cycle_start;
    logic                  oc_cycle_reg;
    logic [`HBPF_CNT_W-1:0] oc_cnt_reg;
    logic                  oc_fault_reg;
    logic                  ot_fault_reg;
    logic                  sh_fault_reg;
    logic                  any_fault;

    assign cycle_start = mod_s.high & !high_d_reg;
    assign any_fault   = oc_fault_reg | ot_fault_reg | sh_fault_reg;

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            high_d_reg   <= 1'h0;
            oc_cycle_reg <= 1'h0;
            oc_cnt_reg   <= '0;
        end
        else
        begin
            high_d_reg <= mod_s.high;
            if (!run_reg)
            begin
                oc_cycle_reg <= 1'h0;
                oc_cnt_reg   <= '0;
            end
            else if (cycle_start)
            begin
                oc_cycle_reg <= 1'h0;
                if (!oc_cycle_reg)
                    oc_cnt_reg <= '0;
            end
            else if (sns_s.oc_high && !oc_cycle_reg)
            begin
                oc_cycle_reg <= 1'h1;
                oc_cnt_reg   <= oc_cnt_reg + `HBPF_CNT_W'(1);
            end
        end
    end

    // ================================================================
    // Fault latches
    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            oc_fault_reg <= 1'h0;
            ot_fault_reg <= 1'h0;
            sh_fault_reg <= 1'h0;
        end
        else if (!run_reg)
        begin
            oc_fault_reg <= 1'h0;
            ot_fault_reg <= 1'h0;
            sh_fault_reg <= 1'h0;
        end
        else
        begin
            if (oc_cnt_reg >= `HBPF_CNT_W'(OC_LIMIT))
                oc_fault_reg <= 1'h1;
            if (sns_s.over_temp)
                ot_fault_reg <= 1'h1;
            if (sns_s.node_short)
                sh_fault_reg <= 1'h1;
        end
    end

    // ================================================================
    // Switch state machine
    hbpf_state_type         state_reg;
    logic [`HBPF_CNT_W-1:0] tri_cnt_reg;
    logic [`HBPF_CNT_W-1:0] neg_cnt_reg;

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
            tri_cnt_reg <= '0;
        else if (!mod_s.mid)
            tri_cnt_reg <= '0;
        else if (tri_cnt_reg < `HBPF_CNT_W'(TRI_HOLD_CYC))
            tri_cnt_reg <= tri_cnt_reg + `HBPF_CNT_W'(1);
    end

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            state_reg   <= HBPF_ST_RUN;
            neg_cnt_reg <= '0;
        end
        else if (!run_reg)
            state_reg <= HBPF_ST_RUN;
        else if (any_fault && state_reg != HBPF_ST_DRAIN)
            state_reg <= HBPF_ST_DRAIN;
        else
        begin
            unique case (state_reg)
                HBPF_ST_RUN:
                begin
                    if (sns_s.neg_limit)
                    begin
                        state_reg   <= HBPF_ST_NEG;
                        neg_cnt_reg <= '0;
                    end
                    else if (tri_cnt_reg == `HBPF_CNT_W'(TRI_HOLD_CYC))
                        state_reg <= HBPF_ST_EMUL;
                end
                HBPF_ST_EMUL:
                    if (sns_s.zero_cross)
                        state_reg <= HBPF_ST_RUN;
                HBPF_ST_NEG:
                begin
                    neg_cnt_reg <= neg_cnt_reg + `HBPF_CNT_W'(1);
                    if (neg_cnt_reg == `HBPF_CNT_W'(NEG_ON_CYC - 1))
                        state_reg <= HBPF_ST_RUN;
                end
                HBPF_ST_DRAIN:
                    ;                                  // Held until enable or supply cycles
            endcase
        end
    end

    // ================================================================
    // Registered outputs
    logic high_next;
    logic low_next;
    logic drained_reg;

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
            drained_reg <= 1'h0;
        else if (state_reg != HBPF_ST_DRAIN)
            drained_reg <= 1'h0;
        else if (sns_s.zero_cross)
            drained_reg <= 1'h1;
    end

    always_comb
    begin
        high_next = 1'h0;
        low_next  = 1'h0;
        if (run_reg)
        begin
            unique case (state_reg)
                HBPF_ST_RUN:
                begin
                    // Fault and per-cycle limit both veto the high side
                    high_next = mod_s.high && !oc_cycle_reg && !sns_s.oc_high && !any_fault;
                    low_next  = !mod_s.high && !mod_s.mid;
                end
                HBPF_ST_EMUL:
                    low_next = sns_s.current_pos && !sns_s.zero_cross;
                HBPF_ST_NEG:
                    // A fault in the pulse cuts it short at once
                    high_next = !any_fault;
                HBPF_ST_DRAIN:
                    low_next = !drained_reg && !sns_s.zero_cross && !sh_fault_reg;
            endcase
        end
    end

    logic [`HBPF_CNT_W-1:0] rep_cnt_reg;

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            high_side_switch     <= 1'h0;
            low_side_switch      <= 1'h0;
            current_sense_out_en <= 1'h0;
            temp_fault_pin       <= 1'h0;
            mod_imp_sel          <= HBPF_IMP_NONE;
            rep_cnt_reg          <= '0;
        end
        else
        begin
            high_side_switch     <= high_next;
            low_side_switch      <= low_next;
            current_sense_out_en <= en_s;
            temp_fault_pin       <= any_fault;
            if (!any_fault)
            begin
                rep_cnt_reg <= '0;
                mod_imp_sel <= HBPF_IMP_NONE;
            end
            else if (rep_cnt_reg < `HBPF_CNT_W'(REPORT_CYC))
                rep_cnt_reg <= rep_cnt_reg + `HBPF_CNT_W'(1);
            else if (sh_fault_reg)
                mod_imp_sel <= HBPF_IMP_SHORT_1K_VDD;
            else if (oc_fault_reg)
                mod_imp_sel <= HBPF_IMP_OC_10K_GND;
            else
                mod_imp_sel <= HBPF_IMP_OT_20K_GND;
        end
    end

    // ================================================================
    // Assertions
    a_fault_blocks_high: assert property (@(posedge clk) disable iff (!rst_int_b)
        any_fault |=> !high_side_switch)
        else $error("High side on while faulted");
    a_neg_no_fault: assert property (@(posedge clk) disable iff (!rst_int_b)
        (state_reg == HBPF_ST_NEG && !any_fault) |=> !temp_fault_pin)
        else $error("Negative limit raised fault");
    a_fault_pin_set: assert property (@(posedge clk) disable iff (!rst_int_b)
        any_fault |=> temp_fault_pin)
        else $error("Fault pin not driven");
    a_imp_delay: assert property (@(posedge clk) disable iff (!rst_int_b)
        $rose(any_fault) |-> mod_imp_sel == HBPF_IMP_NONE [*8])
        else $error("Impedance changed early");
    a_sense_follows_en: assert property (@(posedge clk) disable iff (!rst_int_b)
        !en_s |=> !current_sense_out_en)
        else $error("Sense output active while disabled");
    a_no_run_no_switch: assert property (@(posedge clk) disable iff (!rst_int_b)
        !run_reg |=> !high_side_switch && !low_side_switch)
        else $error("Switching before start");
    a_oc_latch: assert property (@(posedge clk) disable iff (!rst_int_b)
        (run_reg && oc_cnt_reg >= `HBPF_CNT_W'(OC_LIMIT)) |=> oc_fault_reg || !run_reg)
        else $error("Over-current not latched");
    a_emul_no_high: assert property (@(posedge clk) disable iff (!rst_int_b)
        state_reg == HBPF_ST_EMUL |=> !high_side_switch)
        else $error("High side on in emulation");
endmodule

// [logic/hbpf_defines.svh]
// Timing and count constants for the half-bridge phase fault controller
`ifndef HBPF_DEFINES_SVH
`define HBPF_DEFINES_SVH
`define HBPF_CLK_PERIOD_NS   10
`define HBPF_TRI_HOLD_NS     50
`define HBPF_TRI_HOLD_CYC    ((`HBPF_TRI_HOLD_NS + `HBPF_CLK_PERIOD_NS - 1) / `HBPF_CLK_PERIOD_NS)
`define HBPF_NEG_ON_NS       200
`define HBPF_NEG_ON_CYC      (`HBPF_NEG_ON_NS / `HBPF_CLK_PERIOD_NS)
`define HBPF_REPORT_NS       200
`define HBPF_REPORT_CYC      (`HBPF_REPORT_NS / `HBPF_CLK_PERIOD_NS)
`define HBPF_OC_LIMIT        8
`define HBPF_CNT_W           5
`define HBPF_SYNC_W          11
`endif

// [logic/hbpf_pkg.sv]
// Types for the half-bridge phase fault controller
package hbpf_pkg;
    // Decoded three-level modulation input
    typedef struct packed {
        logic high;
        logic mid;
    } hbpf_mod_type;

    // Analog comparator flags
    typedef struct packed {
        logic oc_high;
        logic neg_limit;
        logic zero_cross;
        logic current_pos;
        logic over_temp;
        logic node_short;
    } hbpf_sense_type;

    // Fault type selected onto the modulation pin
    typedef enum logic [1:0] {
        HBPF_IMP_NONE,
        HBPF_IMP_OC_10K_GND,
        HBPF_IMP_OT_20K_GND,
        HBPF_IMP_SHORT_1K_VDD
    } hbpf_imp_type;

    typedef enum logic [1:0] {
        HBPF_ST_RUN,
        HBPF_ST_EMUL,
        HBPF_ST_NEG,
        HBPF_ST_DRAIN
    } hbpf_state_type;
endpackage

// [testbench/hbpf_ctrl_model.sv]
// Modulation controller model that drives the three-level input
`timescale 1ns/100ps
module hbpf_ctrl_model (
    input  wire logic                   clk,
    input  wire logic [1:0]             cmd,
    input  wire hbpf_pkg::hbpf_imp_type mod_imp_sel,
    output hbpf_pkg::hbpf_mod_type      mod_in
);
    import hbpf_pkg::*;
    // ==========================================
    // Pin level
    // Codes: 0 low, 1 high, 2 driven mid, 3 released
    // Released pin floats to mid unless the short fault pull-up holds it high
    always_comb
    begin
        case (cmd)
            2'h1:    mod_in = 2'h2;
            2'h2:    mod_in = 2'h1;
            2'h3:    mod_in = (mod_imp_sel == HBPF_IMP_SHORT_1K_VDD) ? 2'h2 : 2'h1;
            default: mod_in = 2'h0;
        endcase
    end
endmodule

// [testbench/hbpf_ctrl_tb_top.sv]
// Self-checking bench for the half-bridge phase fault controller
`timescale 1ns/100ps
`define HBPF_CHECK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
    $display("wrong value %s expected %h seen %h", nm, e, s); bad_count++; end end
module hbpf_ctrl_tb_top;
    import hbpf_pkg::*;
    // ==========================================
    // Signals
    logic           clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           enable = 1'b0;
    logic           logic_supply_ok = 1'b0;
    logic           driver_supply_ok = 1'b0;
    logic [1:0]     cmd = 2'h0;
    hbpf_sense_type sense_in = '0;
    hbpf_mod_type   mod_in;
    logic           high_side_switch;
    logic           low_side_switch;
    logic           current_sense_out_en;
    logic           temp_fault_pin;
    hbpf_imp_type   mod_imp_sel;
    int             bad_count = 0;
    int             n_compared = 0;
    int             seed = 99556;
    int             q_k[$];
    logic [7:0]     q_e[$];
    logic [7:0]     n_high;
    logic [7:0]     n_both;
    always #5 clk = ~clk;
    hbpf_ctrl_model hbpf_ctrl_model_inst (.clk(clk), .cmd(cmd), .mod_imp_sel(mod_imp_sel), .mod_in(mod_in));
    hbpf_ctrl hbpf_ctrl_inst (
        .clk                  (clk),
        .rst_b                (rst_b),
        .enable               (enable),
        .logic_supply_ok      (logic_supply_ok),
        .driver_supply_ok     (driver_supply_ok),
        .mod_in               (mod_in),
        .sense_in             (sense_in),
        .high_side_switch     (high_side_switch),
        .low_side_switch      (low_side_switch),
        .current_sense_out_en (current_sense_out_en),
        .temp_fault_pin       (temp_fault_pin),
        .mod_imp_sel          (mod_imp_sel)
    );
    // ==========================================
    // Notes and monitor
    function automatic logic [7:0] observe(input int k);
        case (k)
            0:       return {7'h00, high_side_switch};
            1:       return {7'h00, low_side_switch};
            2:       return {7'h00, current_sense_out_en};
            3:       return {7'h00, temp_fault_pin};
            4:       return {6'h00, mod_imp_sel};
            5:       return n_high;
            default: return n_both;
        endcase
    endfunction
    task automatic note(input int k, input logic [7:0] e);
        q_k.push_back(k);
        q_e.push_back(e);
    endtask
    // Compared half a cycle later, when the outputs have settled
    always @(negedge clk)
    begin
        while (q_k.size() > 0)
        begin
            `HBPF_CHECK($sformatf("output %0d", q_k[0]), q_e[0], observe(q_k[0]))
            void'(q_k.pop_front());
            void'(q_e.pop_front());
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One modulation cycle, optionally with over-current in its high part
    task automatic pulse(input logic oc);
        cmd <= 2'h1;
        cyc(4 + ($random(seed) & 3));
        sense_in.oc_high <= oc;
        cyc(8);
        sense_in.oc_high <= 1'b0;
        cyc(3);
        note(0, {7'h00, ~oc});
        cmd <= 2'h0;
        cyc(8);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #(20000 * 10);
        bad_count++;
        end_of_test();
    end
    // ==========================================
    // Scenarios
    initial
    begin
        cyc(4);
        rst_b <= 1'h1;
        cmd <= 2'h1;
        logic_supply_ok <= 1'h1;
        driver_supply_ok <= 1'h1;
        cyc(10);
        note(0, 8'h00);
        note(2, 8'h00);
        enable <= 1'h1;
        cyc(10);
        note(0, 8'h01);
        note(2, 8'h01);
        // Driven and released mid level both request emulation
        sense_in.current_pos <= 1'h1;
        cmd <= 2'h2;
        cyc(10);
        note(0, 8'h00);
        note(1, 8'h01);
        sense_in.current_pos <= 1'h0;
        cyc(8);
        note(1, 8'h00);
        cmd <= 2'h0;
        cyc(8);
        // Low level alone must not end emulation, or the low side would follow it
        note(1, 8'h00);
        sense_in.zero_cross <= 1'h1;
        cyc(6);
        note(1, 8'h01);
        sense_in.zero_cross <= 1'h0;
        sense_in.current_pos <= 1'h1;
        cmd <= 2'h3;
        cyc(12);
        note(1, 8'h01);
        cmd <= 2'h0;
        sense_in.current_pos <= 1'h0;
        sense_in.zero_cross <= 1'h1;
        cyc(10);
        // Negative valley limit: timed high-side pulse, no fault
        sense_in.zero_cross <= 1'h0;
        sense_in.neg_limit <= 1'h1;
        cyc(2);
        sense_in.neg_limit <= 1'h0;
        n_high = 8'h00;
        n_both = 8'h00;
        repeat (40)
        begin
            @(negedge clk);
            n_high = n_high + {7'h00, high_side_switch};
            n_both = n_both + {7'h00, high_side_switch & low_side_switch};
        end
        @(posedge clk);
        note(5, 8'h14);
        note(6, 8'h00);
        note(3, 8'h00);
        // Seven over-currents, one clean cycle, then eight in a row
        repeat (7) pulse(1'h1);
        pulse(1'h0);
        repeat (7) pulse(1'h1);
        note(3, 8'h00);
        sense_in.current_pos <= 1'h1;
        pulse(1'h1);
        note(3, 8'h01);
        cmd <= 2'h1;
        cyc(30);
        note(4, {6'h00, HBPF_IMP_OC_10K_GND});
        note(0, 8'h00);
        note(1, 8'h01);
        sense_in.zero_cross <= 1'h1;
        sense_in.current_pos <= 1'h0;
        cyc(8);
        note(1, 8'h00);
        sense_in.zero_cross <= 1'h0;
        enable <= 1'h0;
        cyc(8);
        note(2, 8'h00);
        enable <= 1'h1;
        cyc(10);
        note(3, 8'h00);
        note(4, {6'h00, HBPF_IMP_NONE});
        note(0, 8'h01);
        // Over-temperature: impedance must hold off exactly 20 cycles after the fault pin
        sense_in.over_temp <= 1'h1;
        sense_in.current_pos <= 1'h1;
        cyc(23);
        note(4, {6'h00, HBPF_IMP_NONE});
        note(0, 8'h00);
        note(1, 8'h01);
        cyc(1);
        note(4, {6'h00, HBPF_IMP_OT_20K_GND});
        note(3, 8'h01);
        sense_in.over_temp <= 1'h0;
        sense_in.zero_cross <= 1'h1;
        cyc(8);
        note(1, 8'h00);
        sense_in.zero_cross <= 1'h0;
        sense_in.current_pos <= 1'h0;
        enable <= 1'h0;
        cyc(8);
        enable <= 1'h1;
        cyc(10);
        // Node short, released pin, cleared by a logic supply cycle
        sense_in.node_short <= 1'h1;
        cmd <= 2'h3;
        cyc(35);
        note(4, {6'h00, HBPF_IMP_SHORT_1K_VDD});
        note(0, 8'h00);
        note(1, 8'h00);
        note(3, 8'h01);
        sense_in.node_short <= 1'h0;
        cmd <= 2'h1;
        logic_supply_ok <= 1'h0;
        cyc(8);
        logic_supply_ok <= 1'h1;
        cyc(10);
        note(3, 8'h00);
        note(4, {6'h00, HBPF_IMP_NONE});
        note(0, 8'h01);
        cyc(2);
        end_of_test();
    end
endmodule
